// *** src/tma_adapter_tx.sv ***
// Purpose: fifo plus multiframe builder driving the T1 line
// Assumes: source and variant pin share clk with this block
// Notes:   a starved payload slot is sent as zero and flagged

`timescale 1ns/100ps

// ---------------------------------------------------------------
// payload fifo
// ---------------------------------------------------------------
module tma_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8   // power of two
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [0:DEPTH-1];  // storage
  logic [AW-1:0] wptr_r;          // write index
  logic [AW-1:0] rptr_r;          // read index
  logic [AW:0]   cnt_r;           // fill level
  logic [AW:0]   cnt_nxt;
  logic          rdy_r;           // registered not-full
  wire           push = in_valid & rdy_r;
  wire           pop  = out_valid & out_ready;

  assign cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready  = rdy_r;
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rptr_r];

  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) mem[wptr_r] <= in_data;
  end

  // pointers and level; ready drops only when the level hits depth
  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
      rdy_r  <= 1'b1;
    end else begin
      wptr_r <= wptr_r + AW'(push);
      rptr_r <= rptr_r + AW'(pop);
      cnt_r  <= cnt_nxt;
      rdy_r  <= (cnt_nxt != (AW+1)'(DEPTH));
    end
  end
endmodule

module tma_adapter_tx
  import tma_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int HALF_CYC   = tma_pkg::LINE_HALF_CYC
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic [7:0]    src_data,   // frame bytes from index -4
  input  wire logic          src_valid,
  output logic               src_ready,
  input  wire logic          hi_prot,    // variant, taken per multiframe
  input  wire logic [63:0]   stamp,      // timestamp, taken per multiframe
  output logic               mf_start,   // pulse at multiframe boundary
  output logic               underrun,   // payload slot found fifo empty
  output logic [12:0]        transported_frame_length,
  tma_line_if.tx             line
);
  import tma_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0] div_r;          // line clock divider
  logic        lclk_r;         // line clock out
  logic        ldat_r;         // line data out
  logic        lsync_r;        // multiframe marker out
  logic        in_fbit_r;      // network bit on the line
  logic [2:0]  bit_r;          // bit within timeslot
  logic [4:0]  ts_r;           // timeslot
  logic [2:0]  fr_r;           // frame in block
  logic [2:0]  bl_r;           // block in superblock
  logic [1:0]  sb_r;           // superblock
  logic [7:0]  sh_r;           // outgoing byte
  logic        var_r;          // variant of this multiframe
  logic [63:0] stamp_r;        // timestamp of this multiframe
  logic        mfs_r;
  logic        und_r;
  logic [12:0] tfl_r;
  logic [7:0]  par_r [0:RS_R_MAX-1];  // rs parity shift register
  logic [7:0]  par_nxt [0:RS_R_MAX-1];
  logic [7:0]  base [0:RS_R_MAX-1];
  logic [7:0]  coef [0:RS_R_MAX-1];

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire tick     = (div_r == 16'(HALF_CYC - 1));
  wire fall     = tick & lclk_r;        // data moves on falling edge
  wire end_slot = fall & ~in_fbit_r & (bit_r == IX_LAST);
  wire end_fr   = end_slot & (ts_r == TS_LAST);
  wire end_bl   = end_fr & (fr_r == IX_LAST);
  wire end_sb   = end_bl & (bl_r == IX_LAST);
  wire end_mf   = end_sb & (sb_r == SB_LAST);
  wire load     = fall & (in_fbit_r | (end_slot & ~end_fr));
  wire [4:0] ld_ts = in_fbit_r ? 5'h00 : ts_r + 5'h01;
  wire [7:0] ld_j  = 8'(fr_r * TS_PER_FR) + {3'b000, ld_ts};
  tma_kind_type kind;
  assign kind = tma_slot_kind(bl_r, fr_r, ld_ts, var_r);
  wire [7:0] f_data;
  wire       f_valid;
  wire       pay_ld = load & (kind == K_PAY);
  wire [7:0] mgmt_b  = {var_r, 2'b00, sb_r, fr_r};
  wire [7:0] stamp_b = stamp_r[{3'(IX_LAST - fr_r), 3'b000} +: 8];
  wire [7:0] fec_b   = var_r ? par_r[RS_R_HP-1] : par_r[RS_R_HI-1];
  // starved payload goes out as zero
  wire [7:0] pay_b   = f_valid ? f_data : 8'h00;
  wire [7:0] ld_b    = (kind == K_MGMT)  ? mgmt_b  :
                       (kind == K_STAMP) ? stamp_b :
                       (kind == K_FEC)   ? fec_b   : pay_b;

  // ---------------------------------------------------------------
  // payload buffer; the sync field is never handed
  // ---------------------------------------------------------------
  tma_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (src_data),
    .in_valid  (src_valid),
    .in_ready  (src_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (pay_ld)
  );

  // ---------------------------------------------------------------
  // reed-solomon encoder, one codeword per block row
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < RS_R_MAX; gi++) begin : g_rs
      // restart at the first byte of every block
      assign base[gi] = (ld_j == 8'h00) ? 8'h00 : par_r[gi];
      assign coef[gi] = var_r ? tma_rs_gen(RS_R_HP, gi)
                              : tma_rs_gen(RS_R_HI, gi);
    end
  endgenerate
  wire [7:0] fb = ld_b ^ (var_r ? base[RS_R_HP-1] : base[RS_R_HI-1]);

  // next parity: shift out on parity slots, divide on data slots
  always_comb begin
    for (int i = 0; i < RS_R_MAX; i++) begin
      if (kind == K_FEC)
        par_nxt[i] = (i == 0) ? 8'h00 : par_r[i-1];
      else
        par_nxt[i] = ((i == 0) ? 8'h00 : base[i-1])
                     ^ tma_gf_mul(fb, coef[i]);
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < RS_R_MAX; i++) begin
      if (rst) par_r[i] <= 8'h00;
      else if (load) par_r[i] <= par_nxt[i];
    end
  end

  // ---------------------------------------------------------------
  // line clock divider; about 1.56 MHz from 100 MHz
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      div_r  <= 16'h0000;
      lclk_r <= 1'b0;
    end else begin
      div_r  <= tick ? 16'h0000 : div_r + 16'h0001;
      lclk_r <= tick ? ~lclk_r : lclk_r;
    end
  end

  // ---------------------------------------------------------------
  // bit serialiser: network bit then 24 timeslots
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      in_fbit_r <= 1'b1;
      bit_r     <= 3'h0;
      sh_r      <= 8'h00;
      ldat_r    <= 1'b0;
      lsync_r   <= 1'b1;
    end else if (load) begin
      sh_r      <= ld_b;
      ldat_r    <= ld_b[7];
      bit_r     <= 3'h0;
      in_fbit_r <= 1'b0;
      lsync_r   <= 1'b0;
    end else if (end_fr) begin
      in_fbit_r <= 1'b1;
      ldat_r    <= 1'b0;       // bit left to the network
      lsync_r   <= end_mf;
    end else if (fall & ~in_fbit_r) begin
      sh_r      <= {sh_r[6:0], 1'b0};
      ldat_r    <= sh_r[6];
      bit_r     <= bit_r + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // position counters
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ts_r <= 5'h00;
      fr_r <= 3'h0;
      bl_r <= 3'h0;
      sb_r <= 2'h0;
    end else begin
      if (load) ts_r <= ld_ts;
      if (end_fr) fr_r <= fr_r + 3'h1;
      if (end_bl) bl_r <= bl_r + 3'h1;
      if (end_mf) sb_r <= 2'h0;
      else if (end_sb) sb_r <= sb_r + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // per-multiframe settings and status
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      var_r   <= 1'b0;
      stamp_r <= 64'h0000000000000000;
      mfs_r   <= 1'b0;
      und_r   <= 1'b0;
      tfl_r   <= TFL_HI;
    end else begin
      mfs_r <= end_mf;
      if (end_mf) begin
        var_r   <= hi_prot;
        stamp_r <= stamp;
      end
      tfl_r <= var_r ? TFL_HP : TFL_HI;
      // a new miss wins over the boundary clear
      if (pay_ld & ~f_valid) und_r <= 1'b1;
      else if (end_mf) und_r <= 1'b0;
    end
  end

  assign line.line_clk  = lclk_r;
  assign line.line_data = ldat_r;
  assign line.line_sync = lsync_r;
  assign mf_start       = mfs_r;
  assign underrun       = und_r;
  assign transported_frame_length = tfl_r;
endmodule

// *** src/tma_pkg.sv ***
// Purpose: shared constants, types and helpers for the T1 multiframe adapter
// Assumes: 100 MHz system clock at both ends of the line
// Notes:   byte positions are classified identically at both ends

package tma_pkg;

  // ---------------------------------------------------------------
  // clock and line timing
  // ---------------------------------------------------------------
  localparam int CLK_NS        = 10;       // system clock period
  localparam int LINE_KBPS     = 1544;     // line bit rate
  localparam int USER_KBPS     = 1536;     // usable by the adapter
  localparam int SIG_KBPS      = 8;        // left to the network
  localparam int FRAME_NS      = 125000;   // nominal frame duration
  localparam int MF_PERIOD_MS  = 24;       // multiframe period
  localparam int LINE_BIT_NS   = 1000000 / LINE_KBPS;  // rounded down
  // half a line bit in system cycles, never below one
  localparam int LINE_HALF_CYC = (LINE_BIT_NS / (2 * CLK_NS)) < 1 ? 1 :
                                 LINE_BIT_NS / (2 * CLK_NS);

  // ---------------------------------------------------------------
  // multiframe geometry
  // ---------------------------------------------------------------
  localparam int MF_FRAMES   = 192;   // frames per multiframe
  localparam int MF_BYTES    = 4608;  // timeslots per multiframe
  localparam int SB_PER_MF   = 3;     // superblocks
  localparam int SB_BYTES    = 1536;
  localparam int BL_PER_SB   = 8;     // blocks per superblock
  localparam int BL_BYTES    = 192;
  localparam int FR_PER_BL   = 8;     // frames per block
  localparam int TS_PER_FR   = 24;    // timeslots per frame
  localparam int TS_BITS     = 8;     // bits per timeslot
  localparam int FRAME_BITS  = 193;   // incl. one network bit

  // ---------------------------------------------------------------
  // capacity split per variant
  // ---------------------------------------------------------------
  localparam int PAY_HI      = 4464;  // high capacity payload
  localparam int FEC_HI      = 96;
  localparam int PAY_HP      = 4320;  // high protection payload
  localparam int FEC_HP      = 240;
  localparam int MGMT_BYTES  = 48;    // both variants
  localparam int IDX_FIRST   = -4;    // first carried frame byte
  localparam int IDX_LAST_HI = 4459;
  localparam int IDX_LAST_HP = 4315;
  localparam logic [12:0] TFL_HI = 13'h1174;  // 4468
  localparam logic [12:0] TFL_HP = 13'h10E4;  // 4324
  localparam int RS_N        = 192;   // shortened codeword
  localparam int RS_R_HI     = 4;     // parity bytes per row
  localparam int RS_R_HP     = 10;
  localparam int RS_R_MAX    = 10;

  // counter terminal counts and the field polynomial
  localparam logic [4:0] TS_LAST = 5'h17;
  localparam logic [2:0] IX_LAST = 3'h7;
  localparam logic [1:0] SB_LAST = 2'h2;
  localparam logic [7:0] RS_POLY = 8'h1D;  // x^8+x^4+x^3+x^2+1

  // kind of a timeslot, gray ordered along the row
  typedef enum logic [1:0] {
    K_PAY   = 2'b00,  // carried frame byte
    K_MGMT  = 2'b01,  // management byte
    K_STAMP = 2'b11,  // timestamp byte
    K_FEC   = 2'b10   // parity byte
  } tma_kind_type;

  // gf(256) multiply
  function automatic logic [7:0] tma_gf_mul(input logic [7:0] a,
                                            input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = {x[6:0], 1'b0} ^ (x[7] ? RS_POLY : 8'h00);
    end
    return p;
  endfunction

  // coefficient k of the generator with r roots alpha^0..alpha^(r-1)
  function automatic logic [7:0] tma_rs_gen(input int r, input int k);
    logic [7:0] g [0:RS_R_MAX];
    logic [7:0] root;
    for (int m = 0; m <= RS_R_MAX; m++) g[m] = 8'h00;
    g[0] = 8'h01;
    root = 8'h01;
    for (int n = 0; n < r; n++) begin
      for (int m = RS_R_MAX; m > 0; m--)
        g[m] = g[m-1] ^ tma_gf_mul(g[m], root);
      g[0] = tma_gf_mul(g[0], root);
      root = tma_gf_mul(root, 8'h02);
    end
    return g[k];
  endfunction

  // classify a timeslot by its place in the block
  function automatic tma_kind_type tma_slot_kind(input logic [2:0] bl,
      input logic [2:0] fr, input logic [4:0] ts, input logic hp);
    logic [7:0] j;
    j = 8'(fr * TS_PER_FR) + {3'b000, ts};
    if (bl == 3'h0 && ts == 5'h00) return K_MGMT;
    else if (bl == 3'h1 && ts == 5'h00) return K_STAMP;
    else if (j >= 8'(RS_N - (hp ? RS_R_HP : RS_R_HI))) return K_FEC;
    else return K_PAY;
  endfunction

endpackage

// *** src/tma_line_if.sv ***
// Purpose: line between the adapter and the far-end receiver
// Assumes: the adapter makes the line clock
// Notes:   data and sync change on the falling line clock edge

`timescale 1ns/100ps

interface tma_line_if;
  logic line_clk;   // line bit clock
  logic line_data;  // serial bit, msb of each timeslot first
  logic line_sync;  // high during the network bit opening a multiframe
  modport tx (output line_clk, output line_data, output line_sync);
  modport rx (input line_clk, input line_data, input line_sync);
endinterface

// *** src/tma_far_end_rx.sv ***
// Purpose: far-end receiver of the T1 multiframe
// Assumes: line signals arrive from another clock and are synchronised
// Notes:   parity bytes are dropped, not checked

`timescale 1ns/100ps

module tma_far_end_rx
  import tma_pkg::*;
#(
  parameter logic [12:0] STAT_POS = 13'h0000  // payload index of link state
) (
  input  wire logic        clk,
  input  wire logic        rst,
  tma_line_if.rx           line,
  input  wire logic        stat_en,     // rewrite the link state byte
  input  wire logic [7:0]  stat_value,
  output logic [7:0]       out_data,
  output logic             out_valid,   // one pulse per payload byte
  output logic             out_first,   // marks frame byte -4
  output logic [63:0]      stamp,
  output logic             stamp_valid,
  output logic [12:0]      transported_frame_length,
  output logic             locked
);
  import tma_pkg::*;

  // ---------------------------------------------------------------
  // synchronisers; stage 1 feeds stage 2 only
  // ---------------------------------------------------------------
  logic [1:0] ck_s;   // line clock
  logic       ck_d;   // delayed for edge detect
  logic [1:0] dt_s;   // line data
  logic [1:0] sy_s;   // line sync
  always_ff @(posedge clk) begin
    if (rst) begin
      ck_s <= 2'b00;
      ck_d <= 1'b0;
      dt_s <= 2'b00;
      sy_s <= 2'b00;
    end else begin
      ck_s <= {ck_s[0], line.line_clk};
      ck_d <= ck_s[1];
      dt_s <= {dt_s[0], line.line_data};
      sy_s <= {sy_s[0], line.line_sync};
    end
  end

  // ---------------------------------------------------------------
  // state and decode
  // ---------------------------------------------------------------
  logic        in_fbit_r;  // next bit is the network bit
  logic        lock_r;
  logic [2:0]  bit_r;
  logic [4:0]  ts_r;
  logic [2:0]  fr_r;
  logic [2:0]  bl_r;
  logic [1:0]  sb_r;
  logic [6:0]  sh_r;
  logic        var_r;
  logic [12:0] pcnt_r;      // payload index within multiframe
  logic [7:0]  od_r;
  logic        ov_r;
  logic        of_r;
  logic [63:0] st_r;
  logic        sv_r;
  wire rise   = ck_s[1] & ~ck_d;
  wire dbit   = rise & lock_r & ~sy_s[1] & ~in_fbit_r;
  wire done   = dbit & (bit_r == IX_LAST);
  wire end_fr = done & (ts_r == TS_LAST);
  wire end_bl = end_fr & (fr_r == IX_LAST);
  wire end_sb = end_bl & (bl_r == IX_LAST);
  wire [7:0] byte_in = {sh_r, dt_s[1]};
  tma_kind_type kind;
  assign kind = tma_slot_kind(bl_r, fr_r, ts_r, var_r);
  wire pay  = done & (kind == K_PAY);
  wire stat = stat_en & (pcnt_r == STAT_POS);

  // ---------------------------------------------------------------
  // framing: sync bit restarts every counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      in_fbit_r <= 1'b0;
      lock_r    <= 1'b0;
      bit_r     <= 3'h0;
      ts_r      <= 5'h00;
      fr_r      <= 3'h0;
      bl_r      <= 3'h0;
      sb_r      <= 2'h0;
      sh_r      <= 7'h00;
    end else if (rise & sy_s[1]) begin
      lock_r    <= 1'b1;   // multiframe start seen
      in_fbit_r <= 1'b0;
      bit_r     <= 3'h0;
      ts_r      <= 5'h00;
      fr_r      <= 3'h0;
      bl_r      <= 3'h0;
      sb_r      <= 2'h0;
    end else if (rise & lock_r & in_fbit_r) begin
      in_fbit_r <= 1'b0;   // network bit skipped
    end else if (dbit) begin
      sh_r  <= byte_in[6:0];
      bit_r <= bit_r + 3'h1;
      if (done) ts_r <= (ts_r == TS_LAST) ? 5'h00 : ts_r + 5'h01;
      if (end_fr) in_fbit_r <= 1'b1;
      if (end_fr) fr_r <= fr_r + 3'h1;
      if (end_bl) bl_r <= bl_r + 3'h1;
      if (end_sb) sb_r <= (sb_r == SB_LAST) ? 2'h0 : sb_r + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // byte sorting: payload out, stamps and variant kept
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      var_r  <= 1'b0;
      pcnt_r <= 13'h0000;
      od_r   <= 8'h00;
      ov_r   <= 1'b0;
      of_r   <= 1'b0;
      st_r   <= 64'h0000000000000000;
      sv_r   <= 1'b0;
    end else begin
      ov_r <= pay;
      sv_r <= done & (kind == K_STAMP) & (fr_r == IX_LAST);
      if (rise & sy_s[1]) pcnt_r <= 13'h0000;
      else if (pay) pcnt_r <= pcnt_r + 13'h0001;
      if (pay) begin
        od_r <= stat ? stat_value : byte_in;
        of_r <= (pcnt_r == 13'h0000);
      end
      if (done & (kind == K_MGMT) & (sb_r == 2'h0) & (fr_r == 3'h0))
        var_r <= byte_in[7];
      if (done & (kind == K_STAMP))
        st_r[{3'(IX_LAST - fr_r), 3'b000} +: 8] <= byte_in;
    end
  end

  logic [12:0] tfl_r;
  always_ff @(posedge clk) begin
    if (rst) tfl_r <= TFL_HI;
    else tfl_r <= var_r ? TFL_HP : TFL_HI;
  end

  assign out_data    = od_r;
  assign out_valid   = ov_r;
  assign out_first   = of_r;
  assign stamp       = st_r;
  assign stamp_valid = sv_r;
  assign locked      = lock_r;
  assign transported_frame_length = tfl_r;
endmodule

// *** testbench/tma_line_chk.sv ***
// Purpose: wire checks on the line between the two adapter ends
// Assumes: line clock made from clk, high protection never selected
// Notes:   position counters follow the bits sampled on line clock rise
`timescale 1ns/100ps
module tma_line_chk #(
  parameter int HALF_CYC = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic line_clk,
  input wire logic line_data,
  input wire logic line_sync
);
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  logic       q_r;     // line clock one clk ago
  logic       seen_r;  // a fall was seen, low phases now complete
  logic [7:0] run_r;   // clks since last line clock edge
  logic [7:0] fbit_r;  // bit within the 193 bit frame
  logic [7:0] frm_r;   // frame within the multiframe
  wire        rise_w = line_clk & ~q_r;
  wire        fall_w = ~line_clk & q_r;
  wire        fend_w = fbit_r == 8'hC0;   // last bit of a frame
  wire        mend_w = frm_r == 8'hBF;    // last frame of multiframe
  wire        f0_w = fbit_r == 8'h00;     // network bit
  wire        mf0_w = f0_w && frm_r == 8'h00;
  // management byte of block 0, variant bit always 0 here
  wire [7:0]  mg_w = {3'b000, frm_r[7:6], frm_r[2:0]};
  wire        mg_w_slot = frm_r[5:3] == 3'h0 && !f0_w && fbit_r < 8'h09;
  wire [2:0]  mg_idx = 3'(8'h08 - fbit_r);  // msb goes first
  // edges and positions; reset restarts the count on the sync bit
  always_ff @(posedge clk) begin
    if (rst) begin
      q_r <= 1'b0;
      seen_r <= 1'b0;
      run_r <= 8'h00;
      fbit_r <= 8'h00;
      frm_r <= 8'h00;
    end else begin
      q_r <= line_clk;
      seen_r <= seen_r | fall_w;
      run_r <= (line_clk != q_r) ? 8'h00 : run_r + 8'h01;
      if (rise_w) fbit_r <= fend_w ? 8'h00 : fbit_r + 8'h01;
      if (rise_w && fend_w) frm_r <= mend_w ? 8'h00 : frm_r + 8'h01;
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_high_len: assert property (fall_w |-> run_r == 8'(HALF_CYC - 1))
    else $error("line clock high phase has wrong length");
  chk_low_len: assert property (rise_w && seen_r |->
      run_r == 8'(HALF_CYC - 1))
    else $error("line clock low phase has wrong length");
  chk_data_hold: assert property (line_clk && q_r |-> $stable(line_data))
    else $error("line data moved while line clock high");
  chk_sync_pos: assert property (rise_w && line_sync |-> mf0_w)
    else $error("sync seen away from multiframe start");
  chk_sync_at_mf: assert property (rise_w && mf0_w |-> line_sync)
    else $error("sync missing at multiframe start");
  chk_sync_width: assert property (rise_w && line_sync |->
      ##[1:8] !line_sync)
    else $error("sync longer than one line bit");
  chk_net_bit: assert property (rise_w && f0_w |-> !line_data)
    else $error("network bit not left at zero");
  chk_mgmt_byte: assert property (rise_w && mg_w_slot |->
      line_data == mg_w[mg_idx])
    else $error("management byte bit wrong");
endmodule

// *** testbench/tma_adapter_tb.sv ***
// Purpose: end to end run of adapter and far-end receiver
// Assumes: line bit shortened to 8 clk through HALF_CYC
// Notes:   the 360 bytes fill the first two blocks; the run stops at the starved first payload slot of block 2
`timescale 1ns/100ps
module tma_adapter_tb;
  import tma_pkg::*;
  localparam int HC = 4;  // half line bit in clk, shortened from LINE_HALF_CYC
  logic        clk, rst, src_valid, src_ready, hi_prot, mf_start, underrun;
  logic        stat_en, out_valid, out_first, stamp_valid, locked, took;
  logic [7:0]  src_data, stat_value, out_data, e;
  logic [63:0] stamp, rx_stamp;
  logic [12:0] tx_tfl, rx_tfl;
  logic [7:0]  exp_q[$];  // bytes still owed by the far end
  int          errors, compares, nbytes, nstamp, i, k;
  integer      seed;
  tma_line_if i_tma_line_if();
  tma_adapter_tx #(.FIFO_DEPTH(8), .HALF_CYC(HC)) i_tma_adapter_tx (
    .clk(clk), .rst(rst), .src_data(src_data), .src_valid(src_valid),
    .src_ready(src_ready), .hi_prot(hi_prot), .stamp(stamp),
    .mf_start(mf_start), .underrun(underrun),
    .transported_frame_length(tx_tfl), .line(i_tma_line_if));
  tma_far_end_rx i_tma_far_end_rx (
    .clk(clk), .rst(rst), .line(i_tma_line_if), .stat_en(stat_en),
    .stat_value(stat_value), .out_data(out_data), .out_valid(out_valid),
    .out_first(out_first), .stamp(rx_stamp), .stamp_valid(stamp_valid),
    .transported_frame_length(rx_tfl), .locked(locked));
  tma_line_chk #(.HALF_CYC(HC)) i_tma_line_chk (
    .clk(clk), .rst(rst), .line_clk(i_tma_line_if.line_clk),
    .line_data(i_tma_line_if.line_data),
    .line_sync(i_tma_line_if.line_sync));
  // ---------------------------------------------------------------
  // clock, compare and verdict
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // far end watcher; outputs settle by the falling edge
  always @(negedge clk) begin
    if (out_valid === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 8'h00;  // starved slot is 0
      check(64'(out_data), 64'(e));
      check(64'(out_first), 64'(nbytes == 0));
      nbytes++;
    end
    if (stamp_valid === 1'b1) begin
      check(rx_stamp, 64'h0);
      nstamp++;
    end
    // a whole multiframe is longer than the run, so no boundary may show
    if (mf_start !== 1'b0) check(64'(mf_start), 64'h0);
  end
  // ---------------------------------------------------------------
  // main sequence: random paced source, then starve it
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h0191F6BB;
    {errors, compares, nbytes, nstamp, k} = '0;
    {rst, src_valid, src_data, hi_prot, stamp} = {1'b1, 74'h0};
    {stat_en, stat_value} = {1'b1, 8'hA5};  // far end rewrites link state
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    for (i = 0; i < 40000 && k < 360; i++) begin
      @(negedge clk);
      took = src_valid & src_ready;
      @(posedge clk);
      #1 stamp = {$random(seed), $random(seed)};
      if (took) begin
        exp_q.push_back(k == 0 ? stat_value : src_data);
        k++;
      end
      if (took || !src_valid) begin
        src_valid = (($random(seed) & 3) != 0) && k < 360;
        src_data = 8'($random(seed));
      end
    end
    if (i == 40000) errors++;
    check(64'(underrun), 64'h0);
    for (i = 0; i < 30000; i++) begin
      if (exp_q.size() == 0 && nstamp > 0 && underrun === 1'b1) break;
      @(posedge clk);
    end
    if (i == 30000) errors++;
    check(64'(tx_tfl), 64'(TFL_HI));
    check(64'(rx_tfl), 64'(TFL_HI));
    check(64'(locked), 64'h1);
    wrap_up();
  end
endmodule
